// File: rtl/ppr_pkg.sv
package ppr_pkg;
  typedef logic [7:0] ppr_byte_t;
  typedef logic [2:0] ppr_pe_t;
  typedef enum logic [1:0] {
    PPR_RST_IDLE = 2'b00,
    PPR_RST_LOW  = 2'b01,
    PPR_RST_HELD = 2'b11
  } ppr_rst_state_t;
endpackage

// File: rtl/ppr_map.svh
`ifndef PPR_MAP_SVH
`define PPR_MAP_SVH
`define PPR_W_8          8
`define PPR_W_E          3
`define PPR_BIT_RXD      4
`define PPR_BIT_EXTERNAL_INTERRUPT_ZERO     6
`define PPR_BIT_RST      0
`define PPR_BIT_XIN      1
`define PPR_BIT_XOUT     2
`define PPR_RST_MIN_NS   400
`define PPR_CLK_NS       4
`define PPR_RST_CYC      ((`PPR_RST_MIN_NS + `PPR_CLK_NS - 1) / `PPR_CLK_NS)
`endif

// File: rtl/ppr_if.sv
`timescale 1ns/1ps
interface ppr_bit_if #(parameter int W = 8);
  logic [W-1:0] pin_in;
  logic [W-1:0] sync_in;
  modport pad  (input pin_in, output sync_in);
  modport core (output pin_in, input sync_in);
endinterface

// File: rtl/ppr_sync.sv
`timescale 1ns/1ps
module ppr_sync #(
  parameter int W = 8
) (
  input  wire logic core_clk_i,
  input  wire logic rst_n_i,
  ppr_bit_if.pad    bus
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] val;
  } ppr_sync_st_t;
  ppr_sync_st_t st;
  ppr_sync_st_t next_st;

  // a change is taken only once stages two and three agree
  always_comb begin
    next_st    = st;
    next_st.s1 = bus.pin_in;
    next_st.s2 = st.s1;
    next_st.s3 = st.s2;
    for (int i = 0; i < W; i++) begin
      if (st.s2[i] == st.s3[i]) begin
        next_st.val[i] = st.s3[i];
      end
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign bus.sync_in = st.val;
endmodule

// File: rtl/ppr_ports.sv
`timescale 1ns/1ps
`include "ppr_map.svh"
// Function
// - ports B, C and D are eight bits each, every bit separately input or output.
// - port E has three bits, positions zero to two.
// - each bit has its own pull-up enable.
// - any active reset puts every pin in high impedance, but only on a core clock edge; a pin reset leaves the oscillator amplifier output enabled.
// - with the reset-disable fuse programmed, port E bit zero is ordinary I/O.
// - with the fuse unprogrammed, a long enough low on port E bit zero resets the device.
// - clock fuses can give port E bits one and two to the oscillator amplifier.
// - port D bit four feeds UART and LIN receive, capture A, alternate clock, pin change 20.
// - port D bit six feeds external interrupt zero and pin change 22.
// - port E bit zero also carries the debug line and pin change 24.
// - port E bit one can carry the timer 0 compare B output and pin change 25.
module ppr_ports
  import ppr_pkg::*;
#(
  parameter int RST_CYC = `PPR_RST_CYC
) (
  input  wire logic      core_clk_i,
  input  wire logic      rst_n_i,
  input  wire logic      reset_pin_disable_fuse_i,
  input  wire logic      osc_pins_sel_i,
  input  wire ppr_byte_t b_out_i,
  input  wire ppr_byte_t b_dir_i,
  input  wire ppr_byte_t b_pu_i,
  input  wire ppr_byte_t c_out_i,
  input  wire ppr_byte_t c_dir_i,
  input  wire ppr_byte_t c_pu_i,
  input  wire ppr_byte_t d_out_i,
  input  wire ppr_byte_t d_dir_i,
  input  wire ppr_byte_t d_pu_i,
  input  wire ppr_pe_t   e_out_i,
  input  wire ppr_pe_t   e_dir_i,
  input  wire ppr_pe_t   e_pu_i,
  input  wire logic      debug_en_i,
  input  wire logic      debug_out_i,
  input  wire logic      debug_oe_i,
  input  wire logic      timer0_cmp_b_en_i,
  input  wire logic      timer0_compare_b_out_i,
  input  wire ppr_byte_t b_pin_i,
  input  wire ppr_byte_t c_pin_i,
  input  wire ppr_byte_t d_pin_i,
  input  wire ppr_pe_t   e_pin_i,
  output ppr_byte_t      b_pin_o,
  output ppr_byte_t      b_pin_oe_o,
  output ppr_byte_t      b_pullup_o,
  output ppr_byte_t      c_pin_o,
  output ppr_byte_t      c_pin_oe_o,
  output ppr_byte_t      c_pullup_o,
  output ppr_byte_t      d_pin_o,
  output ppr_byte_t      d_pin_oe_o,
  output ppr_byte_t      d_pullup_o,
  output ppr_pe_t        e_pin_o,
  output ppr_pe_t        e_pin_oe_o,
  output ppr_pe_t        e_pullup_o,
  output ppr_byte_t      b_in_o,
  output ppr_byte_t      c_in_o,
  output ppr_byte_t      d_in_o,
  output ppr_pe_t        e_in_o,
  output logic           uart_receive_o,
  output logic           lin_receive_line_o,
  output logic           timer1_capture_in_a_o,
  output logic           alt_serial_clk_o,
  output logic           external_interrupt_zero_o,
  output logic           onchip_debug_io_o,
  output logic [26:0]    pin_change_o,
  output logic           osc_amp_input_o,
  output logic           osc_amp_output_oe_o,
  output logic           pin_reset_o
);
  localparam int CW = $clog2(RST_CYC + 1);

  typedef struct packed {
    ppr_rst_state_t rst_st;
    logic [CW-1:0]  rst_cnt;
    logic           pin_reset;
    ppr_byte_t      b_o, b_oe, b_pu, c_o, c_oe, c_pu, d_o, d_oe, d_pu;
    ppr_pe_t        e_o, e_oe, e_pu;
    ppr_byte_t      b_in, c_in, d_in;
    ppr_pe_t        e_in;
    logic           xin_sel;
  } ppr_st_t;
  ppr_st_t st;
  ppr_st_t next_st;

  logic [26:0] sync_in;
  ppr_bit_if #(.W(27)) sif ();
  assign sif.pin_in = {e_pin_i, d_pin_i, c_pin_i, b_pin_i};
  assign sync_in    = sif.sync_in;

  ppr_sync #(.W(27)) u_sync (
    .core_clk_i (core_clk_i),
    .rst_n_i    (rst_n_i),
    .bus        (sif)
  );

  // pads go high impedance on the edge that samples rst_n_i, or one cycle after pin_reset is set; the synchronous
  // reset relies on the reset generator still clocking this logic
  always_comb begin
    next_st = st;
    next_st.b_o  = b_out_i;
    next_st.b_oe = b_dir_i;
    next_st.b_pu = b_pu_i & ~b_dir_i;
    next_st.c_o  = c_out_i;
    next_st.c_oe = c_dir_i;
    next_st.c_pu = c_pu_i & ~c_dir_i;
    next_st.d_o  = d_out_i;
    next_st.d_oe = d_dir_i;
    next_st.d_pu = d_pu_i & ~d_dir_i;
    next_st.e_o  = e_out_i;
    next_st.e_oe = e_dir_i;
    next_st.e_pu = e_pu_i & ~e_dir_i;
    next_st.b_in = sync_in[7:0];
    next_st.c_in = sync_in[15:8];
    next_st.d_in = sync_in[23:16];
    next_st.e_in = sync_in[26:24];
    next_st.xin_sel = osc_pins_sel_i;
    if (debug_en_i) begin
      next_st.e_o[`PPR_BIT_RST]  = debug_out_i;
      next_st.e_oe[`PPR_BIT_RST] = debug_oe_i;
      next_st.e_pu[`PPR_BIT_RST] = ~debug_oe_i;
    end else if (!reset_pin_disable_fuse_i) begin
      next_st.e_oe[`PPR_BIT_RST] = 1'b0;
      next_st.e_pu[`PPR_BIT_RST] = 1'b1;
    end
    if (timer0_cmp_b_en_i) begin
      next_st.e_o[`PPR_BIT_XIN]  = timer0_compare_b_out_i;
      next_st.e_oe[`PPR_BIT_XIN] = 1'b1;
    end
    if (osc_pins_sel_i) begin
      next_st.e_oe[2:1] = 2'b00;
      next_st.e_pu[2:1] = 2'b00;
    end
    // pin reset filter: only a low seen for RST_CYC + 1 cycles fires
    next_st.pin_reset = 1'b0;
    case (st.rst_st)
      PPR_RST_IDLE: begin
        next_st.rst_cnt = '0;
        if (!reset_pin_disable_fuse_i && !sync_in[24]) begin
          next_st.rst_st = PPR_RST_LOW;
        end
      end
      PPR_RST_LOW: begin
        if (reset_pin_disable_fuse_i || sync_in[24]) begin
          next_st.rst_st = PPR_RST_IDLE;
        end else if (st.rst_cnt == CW'(RST_CYC - 1)) begin
          next_st.rst_st    = PPR_RST_HELD;
          next_st.pin_reset = 1'b1;
        end else begin
          next_st.rst_cnt = st.rst_cnt + 1'b1;
        end
      end
      PPR_RST_HELD: begin
        next_st.pin_reset = ~sync_in[24] & ~reset_pin_disable_fuse_i;
        if (sync_in[24] || reset_pin_disable_fuse_i) begin
          next_st.rst_st = PPR_RST_IDLE;
        end
      end
      default: begin
        next_st.rst_st = PPR_RST_IDLE;
      end
    endcase
    if (st.pin_reset) begin
      next_st.b_oe = '0;
      next_st.c_oe = '0;
      next_st.d_oe = '0;
      next_st.e_oe = '0;
      next_st.b_pu = '0;
      next_st.c_pu = '0;
      next_st.d_pu = '0;
      next_st.e_pu = 3'h1;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  logic [26:0] pc_q;
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      pc_q <= '0;
    end else begin
      pc_q <= {st.e_in, st.d_in, st.c_in, st.b_in};
    end
  end

  logic dbg_q;
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      dbg_q <= 1'b0;
    end else begin
      dbg_q <= debug_en_i & st.e_in[`PPR_BIT_RST];
    end
  end


  assign b_pin_o    = st.b_o;
  assign b_pin_oe_o = st.b_oe;
  assign b_pullup_o = st.b_pu;
  assign c_pin_o    = st.c_o;
  assign c_pin_oe_o = st.c_oe;
  assign c_pullup_o = st.c_pu;
  assign d_pin_o    = st.d_o;
  assign d_pin_oe_o = st.d_oe;
  assign d_pullup_o = st.d_pu;
  assign e_pin_o    = st.e_o;
  assign e_pin_oe_o = st.e_oe;
  assign e_pullup_o = st.e_pu;
  assign b_in_o     = st.b_in;
  assign c_in_o     = st.c_in;
  assign d_in_o     = st.d_in;
  assign e_in_o     = st.e_in;
  assign uart_receive_o            = st.d_in[`PPR_BIT_RXD];
  assign lin_receive_line_o        = st.d_in[`PPR_BIT_RXD];
  assign timer1_capture_in_a_o     = st.d_in[`PPR_BIT_RXD];
  assign alt_serial_clk_o          = st.d_in[`PPR_BIT_RXD];
  assign external_interrupt_zero_o = st.d_in[`PPR_BIT_EXTERNAL_INTERRUPT_ZERO];
  assign onchip_debug_io_o         = dbg_q;
  assign pin_change_o              = pc_q;
  assign osc_amp_input_o           = st.xin_sel;
  assign osc_amp_output_oe_o       = st.xin_sel;
  assign pin_reset_o               = st.pin_reset;
endmodule

// File: verif/ppr_board.sv
`timescale 1ns/1ps
module ppr_board #(
  parameter int W = 8
) (
  input  wire logic [W-1:0] oe_i,
  input  wire logic [W-1:0] out_i,
  input  wire logic [W-1:0] pu_i,
  input  wire logic [W-1:0] ext_i,
  input  wire logic [W-1:0] ext_en_i,
  output logic      [W-1:0] pad_o
);
  // floating pad reads high with the pull-up on, else the inverse of out_i, so a stale value never passes
  assign pad_o = (oe_i & out_i) | (~oe_i & ext_en_i & ext_i)
               | (~oe_i & ~ext_en_i & (pu_i | ~out_i));
endmodule

// File: verif/ppr_ports_properties.sv
`timescale 1ns/1ps
module ppr_ports_properties
  import ppr_pkg::*;
#(
  parameter int RST_CYC = 4
) (
  input wire logic      core_clk_i,
  input wire logic      rst_n_i,
  input wire logic      reset_pin_disable_fuse_i,
  input wire logic      osc_pins_sel_i,
  input wire ppr_byte_t b_dir_i,
  input wire ppr_byte_t b_pu_i,
  input wire logic      timer0_cmp_b_en_i,
  input wire logic      timer0_compare_b_out_i,
  input wire ppr_byte_t b_pin_i,
  input wire ppr_pe_t   e_pin_i,
  input wire ppr_byte_t b_pin_oe_o,
  input wire ppr_byte_t b_pullup_o,
  input wire ppr_pe_t   e_pin_o,
  input wire ppr_pe_t   e_pin_oe_o,
  input wire ppr_byte_t b_in_o,
  input wire ppr_byte_t c_in_o,
  input wire ppr_byte_t d_in_o,
  input wire ppr_pe_t   e_in_o,
  input wire logic      uart_receive_o,
  input wire logic      external_interrupt_zero_o,
  input wire logic [26:0] pin_change_o,
  input wire logic      osc_amp_input_o,
  input wire logic      pin_reset_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);
  logic live;
  always_ff @(posedge core_clk_i) live <= rst_n_i && !pin_reset_o;
  dir_oe_a: assert property (live |-> b_pin_oe_o == $past(b_dir_i))
    else $error("port b enable wrong");
  pu_sel_a: assert property (live |-> b_pullup_o == ($past(b_pu_i) & ~$past(b_dir_i)))
    else $error("port b pullup wrong");
  pin_tri_a: assert property (pin_reset_o |=> b_pin_oe_o == 0 && e_pin_oe_o == 0)
    else $error("pins driven in reset");
  in_sync_a: assert property ((rst_n_i && $stable(b_pin_i))[*6] |-> b_in_o == b_pin_i)
    else $error("input not readable");
  alt_fan_a: assert property (uart_receive_o == d_in_o[4] && external_interrupt_zero_o == d_in_o[6])
    else $error("alternate input wrong");
  pc_delay_a: assert property ($past(rst_n_i) |->
    pin_change_o == $past({e_in_o, d_in_o, c_in_o, b_in_o}))
    else $error("pin change wrong");
  cmp_b_a: assert property ($past(timer0_cmp_b_en_i && !osc_pins_sel_i) && live |->
    e_pin_oe_o[1] && e_pin_o[1] == $past(timer0_compare_b_out_i))
    else $error("compare b not driven");
  osc_own_a: assert property (osc_amp_input_o == $past(osc_pins_sel_i) &&
    (!osc_amp_input_o || e_pin_oe_o[2:1] == 0))
    else $error("oscillator pins driven");
  fuse_io_a: assert property (reset_pin_disable_fuse_i[*3] |-> !pin_reset_o)
    else $error("reset with fuse set");
  rst_filt_a: assert property ((!reset_pin_disable_fuse_i && !e_pin_i[0])[*8] |->
    ##[0:8] pin_reset_o)
    else $error("long low gave no reset");
endmodule

// File: verif/ppr_ports_tb.sv
`timescale 1ns/1ps
module ppr_ports_tb;
  import ppr_pkg::*;
  localparam int RST_CYC = 4;
  logic core_clk_i, rst_n_i, reset_pin_disable_fuse_i, osc_pins_sel_i, debug_en_i, debug_out_i;
  logic debug_oe_i, timer0_cmp_b_en_i, timer0_compare_b_out_i, uart_receive_o, lin_receive_line_o;
  logic timer1_capture_in_a_o, alt_serial_clk_o, external_interrupt_zero_o, onchip_debug_io_o;
  logic osc_amp_input_o, osc_amp_output_oe_o, pin_reset_o;
  logic [26:0] pin_change_o;
  ppr_byte_t b_out_i, b_dir_i, b_pu_i, c_out_i, c_dir_i, c_pu_i, d_out_i, d_dir_i, d_pu_i, bx;
  ppr_byte_t b_pin_i, c_pin_i, d_pin_i, b_pin_o, b_pin_oe_o, b_pullup_o, c_pin_o, c_pin_oe_o;
  ppr_byte_t c_pullup_o, d_pin_o, d_pin_oe_o, d_pullup_o, b_in_o, c_in_o, d_in_o, bx_en;
  ppr_pe_t e_out_i, e_dir_i, e_pu_i, e_pin_i, e_pin_o, e_pin_oe_o, e_pullup_o, e_in_o, ex, ex_en;
  int err_count, checked, cyc;
  assign c_pin_i = b_pin_i;
  assign d_pin_i = ~b_pin_i;
  ppr_ports #(.RST_CYC(RST_CYC)) dut_u (.*);
  ppr_board #(.W(8)) bb_u (.oe_i(b_pin_oe_o), .out_i(b_pin_o), .pu_i(b_pullup_o), .ext_i(bx),
    .ext_en_i(bx_en), .pad_o(b_pin_i));
  ppr_board #(.W(3)) eb_u (.oe_i(e_pin_oe_o), .out_i(e_pin_o), .pu_i(e_pullup_o), .ext_i(ex),
    .ext_en_i(ex_en), .pad_o(e_pin_i));
  initial begin
    core_clk_i = 0;
    forever #2 core_clk_i = ~core_clk_i;
  end
  task summarize;
    $display("%0d checks, %0d mismatches", checked, err_count);
    if (err_count == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      err_count++;
      $display("CHECK FAILED %s exp %h got %h", n, e, g);
    end
  endtask
  task step(input int n);
    repeat (n) @(posedge core_clk_i);
    #1;
  endtask
  task t_drive;
    @(posedge core_clk_i);
    {b_dir_i, b_out_i, b_pu_i} <= {8'ha5, 8'h3c, 8'hff};
    {c_dir_i, c_out_i, d_dir_i, d_out_i} <= {4{8'h0f}};
    {c_pu_i, d_pu_i} <= 16'hffff;
    {e_dir_i, e_out_i, e_pu_i} <= {3'h5, 3'h4, 3'h7};
    step(8);
    chk("b oe", 8'ha5, b_pin_oe_o);
    chk("b pullup", 8'h5a, b_pullup_o);
    chk("c oe", 8'h0f, c_pin_oe_o);
    chk("e oe", 3'h5, e_pin_oe_o);
    chk("b in", 8'h7e, b_in_o);
    chk("e in", 3'h6, e_in_o);
    chk("bcd out", 24'h3c0f0f, {b_pin_o, c_pin_o, d_pin_o});
    chk("cd oe pu", 24'h0ff0f0, {d_pin_oe_o, c_pullup_o, d_pullup_o});
    chk("e out pu", 6'h22, {e_pin_o, e_pullup_o});
    chk("c d in", 16'h7e81, {c_in_o, d_in_o});
    $display("drive test done");
  endtask
  task t_alt;
    @(posedge core_clk_i);
    {b_dir_i, c_dir_i, d_dir_i, e_dir_i} <= '0;
    {bx_en, bx} <= {8'hff, 8'haf};
    {timer0_cmp_b_en_i, timer0_compare_b_out_i} <= 2'b11;
    {debug_en_i, debug_out_i, debug_oe_i} <= 3'b111;
    step(8);
    chk("rx d4", 1, uart_receive_o);
    chk("d4 fan", 3'h7, {lin_receive_line_o, timer1_capture_in_a_o, alt_serial_clk_o});
    chk("external_interrupt_zero d6", 1, external_interrupt_zero_o);
    chk("pc 22 20", 2'b11, {pin_change_o[22], pin_change_o[20]});
    chk("cmp b", 2'b11, {e_pin_oe_o[1], e_pin_o[1]});
    chk("debug", 3'h7, {e_pin_oe_o[0], e_pin_o[0], onchip_debug_io_o});
    chk("b in alt", 8'haf, b_in_o);
    @(posedge core_clk_i) osc_pins_sel_i <= 1;
    step(3);
    chk("osc", 4'hc, {osc_amp_input_o, osc_amp_output_oe_o, e_pin_oe_o[2:1]});
    @(posedge core_clk_i) {osc_pins_sel_i, timer0_cmp_b_en_i, debug_en_i} <= '0;
    $display("alternate test done");
  endtask
  task t_rst_pin;
    @(posedge core_clk_i) {reset_pin_disable_fuse_i, ex} <= {1'b0, 3'h6};
    // three low cycles pass the synchroniser but stay under the filter length
    repeat (3) @(posedge core_clk_i);
    ex <= 3'h7;
    step(12);
    chk("short low", 0, pin_reset_o);
    @(posedge core_clk_i) {ex, b_dir_i} <= {3'h6, 8'hff};
    step(16);
    chk("long low", 1, pin_reset_o);
    chk("tristate", 0, {b_pin_oe_o, e_pin_oe_o});
    // fuse flips while the pin is still low: plain I/O must win at once
    @(posedge core_clk_i) reset_pin_disable_fuse_i <= 1;
    step(10);
    chk("fuse io", 0, {pin_reset_o, pin_change_o[24]});
    chk("b oe back", 8'hff, b_pin_oe_o);
    $display("reset pin test done");
  endtask
  always @(posedge core_clk_i) begin
    cyc++;
    if (cyc == 2000) begin
      err_count++;
      summarize();
    end
  end
  initial begin
    {rst_n_i, reset_pin_disable_fuse_i, osc_pins_sel_i, debug_en_i} <= 4'h4;
    {debug_out_i, debug_oe_i, timer0_cmp_b_en_i, timer0_compare_b_out_i, bx, bx_en} <= '0;
    {b_out_i, b_dir_i, b_pu_i, c_out_i, c_dir_i, c_pu_i, d_out_i, d_dir_i, d_pu_i} <= '0;
    {e_out_i, e_dir_i, e_pu_i, ex, ex_en} <= {9'h0, 6'h3f};
    step(10);
    chk("reset oe", 0, {b_pin_oe_o, e_pin_oe_o, b_pullup_o});
    step(9);
    @(posedge core_clk_i) rst_n_i <= 1;
    t_drive();
    t_alt();
    t_rst_pin();
    summarize();
  end
endmodule
bind ppr_ports ppr_ports_properties #(.RST_CYC(RST_CYC)) chk_u (.*);
